//--- hdl/dmc_top.sv
// Dosing mode controller: analog, pulse, batch and cycle timer pacing
//
// Notes on behaviour
// - Analog flow is line through two points
// - Outside point span, hold nearer point flow
// - Current above 22 mA flags over-range
// - At or below 0.5 mA, zero flow, flag
// - Above 0.5 mA again, clear flag, resume
// - Dose only while running; toggles flip run, two at once cancel
// - Pulse mode: volume per pulse count, rate tracking
// - Pulse qualification width 4 to 60 ms
// - Flag not synchronised before two pulses
// - Clamp pulse flow at maximum, flag excess
// - Batch trigger doses volume over set time
// - Flag batch or cycle flow above maximum
// - Dosing flag from trigger until batch ends
// - Accumulate extra triggers, run extra batches
// - Without accumulation, trigger restarts batch
// - Expose remaining volume, time and percent
// - Cycle timer waits delay before first cycle
// - Dose duration, idle rest, repeat forever
// - Start begins timer; toggle cancels sequence
// - Delay once per start; expose phase, remaining
`timescale 1ns/1ps
module dmc_top
  import dmc_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
)(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] ana_current,
  input wire logic fast_digital_input,
  input wire logic remote_toggle,
  output logic [15:0] flow_cmd,
  output logic pump_run
);
  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Saturate a wide value into a 16-bit flow
  function automatic logic [15:0] sat16(input logic [41:0] v);
    sat16 = (v > 42'h000_0000_FFFF) ? 16'hFFFF : v[15:0];
  endfunction

  // Two-point line with plateau beyond both points
  function automatic logic [15:0] interp(input logic [15:0] c, input logic [15:0] c1,
    input logic [15:0] f1, input logic [15:0] c2, input logic [15:0] f2);
    logic signed [35:0] num;
    logic signed [35:0] q;
    num = ($signed({20'h0_0000, c}) - $signed({20'h0_0000, c1}))
      * ($signed({20'h0_0000, f2}) - $signed({20'h0_0000, f1}));
    q = 36'sh0_0000_0000;
    if (c1 == c2)
      interp = f1;
    else if ((c1 < c2) ? (c <= c1) : (c >= c1))
      interp = f1;
    else if ((c1 < c2) ? (c >= c2) : (c <= c2))
      interp = f2;
    else
    begin
      q = num / ($signed({20'h0_0000, c2}) - $signed({20'h0_0000, c1}));
      interp = 16'(q + $signed({20'h0_0000, f1}));
    end
  endfunction

  // Flow per hour from one pulse interval; a zero count or interval acts as one
  function automatic logic [16:0] pulse_rate(input logic [19:0] vol, input logic [13:0] cnt,
    input logic [21:0] per);
    logic [41:0] den;
    logic [41:0] q;
    den = ((cnt == 14'h0000) ? 42'h1 : 42'(cnt)) * ((per == 22'h00_0000) ? 42'h1 : 42'(per));
    q = (42'(vol) * MS_PER_HOUR) / den;
    pulse_rate = (q > 42'h1_FFFF) ? 17'h1_FFFF : q[16:0];
  endfunction

  // ****************************************************************
  // Registers and state
  // ****************************************************************
  logic [1:0] mode_r;
  logic accum_en_r;
  logic [15:0] p1_cur_r, p1_flow_r, p2_cur_r, p2_flow_r;
  logic [13:0] pul_cnt_r;
  logic [19:0] pul_vol_r, bat_vol_r;
  logic [5:0] qual_r;
  logic [16:0] bat_time_r;
  logic [10:0] cyc_delay_r, cyc_dur_r, cyc_period_r;
  logic [15:0] cyc_flow_r, flow_max_r;
  logic [16:0] tick_cnt_r;
  logic tick;
  logic pace_meta_r, pace_sync_r, rem_meta_r, rem_sync_r, rem_d_r;
  logic [5:0] qual_cnt_r;
  logic trig;
  logic run_r;
  logic los_r, ovr_r;
  logic [21:0] period_r;
  logic [1:0] seen_r;
  logic [16:0] rate_r;
  logic dosing_r;
  logic [16:0] rem_s_r;
  logic [15:0] acc_r, bsub_r;
  dmc_ct_state_t ct_r;
  logic [10:0] ct_rem_r;
  logic [15:0] csub_r;
  logic [15:0] flow_r;
  logic [31:0] prdata_r;
  logic rdy_r;
  logic [19:0] rem_vol_r;
  logic [6:0] pct_r;
  logic wr_en, toggle, nosync, maxexc, bat_inv, cyc_inv;
  logic [5:0] qual_ms;
  logic [31:0] bat_flow;
  logic [16:0] bat_div;
  logic [15:0] ana_flow;
  logic [10:0] off_min;
  logic [31:0] rd_mux;
  logic unmapped;

  // ****************************************************************
  // APB slave, zero wait states with ce high
  // ****************************************************************
  // Read data is captured in the setup cycle so it comes from a flop
  assign pready = psel && penable && rdy_r && ce;
  assign wr_en = pready && pwrite;
  assign prdata = prdata_r;
  assign pslverr = pready && unmapped;
  assign toggle = (wr_en && paddr == OFS_CTRL && pwdata[CTRL_TOGGLE])
    ^ (rem_sync_r && !rem_d_r);

  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      prdata_r <= 32'h0000_0000;
      rdy_r <= 1'b0;
    end
    else if (ce)
    begin
      prdata_r <= rd_mux;
      rdy_r <= psel && !(penable && rdy_r);
    end

  // Read decode; status bits give the block's live state
  always_comb
  begin
    unmapped = 1'b0;
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      OFS_CTRL: rd_mux = {29'h0, accum_en_r, mode_r};
      OFS_AN_P1: rd_mux = {p1_flow_r, p1_cur_r};
      OFS_AN_P2: rd_mux = {p2_flow_r, p2_cur_r};
      OFS_PUL_CNT: rd_mux = {18'h0_0000, pul_cnt_r};
      OFS_PUL_VOL: rd_mux = {12'h000, pul_vol_r};
      OFS_QUAL: rd_mux = {26'h000_0000, qual_r};
      OFS_BAT_VOL: rd_mux = {12'h000, bat_vol_r};
      OFS_BAT_TIME: rd_mux = {15'h0000, bat_time_r};
      OFS_CYC_DELAY: rd_mux = {21'h00_0000, cyc_delay_r};
      OFS_CYC_DUR: rd_mux = {cyc_flow_r, 5'h00, cyc_dur_r};
      OFS_CYC_PERIOD: rd_mux = {21'h00_0000, cyc_period_r};
      OFS_FLOW_MAX: rd_mux = {16'h0000, flow_max_r};
      OFS_STATUS: rd_mux = {5'h00, ct_rem_r, 6'h00, ct_r, cyc_inv, bat_inv, dosing_r,
        maxexc, nosync, ovr_r, los_r, run_r};
      OFS_FLOW: rd_mux = {16'h0000, flow_r};
      OFS_REM_VOL: rd_mux = {12'h000, rem_vol_r};
      OFS_REM_TIME: rd_mux = {15'h0000, rem_s_r};
      OFS_REM_PCT: rd_mux = {25'h000_0000, pct_r};
      default: unmapped = 1'b1;
    endcase
  end

  // Configuration writes; point currents are held within 0 to 20 mA
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      mode_r <= MODE_ANALOG;
      accum_en_r <= 1'b0;
      {p1_cur_r, p1_flow_r, p2_cur_r, p2_flow_r} <= 64'h0000_0000_0000_0000;
      pul_cnt_r <= RST_PUL_CNT;
      pul_vol_r <= RST_VOL;
      bat_vol_r <= RST_VOL;
      qual_r <= RST_QUAL;
      bat_time_r <= RST_BAT_TIME;
      cyc_delay_r <= RST_CYC_MIN;
      cyc_dur_r <= RST_CYC_MIN;
      cyc_period_r <= RST_CYC_PERIOD;
      cyc_flow_r <= 16'h0000;
      flow_max_r <= RST_FLOW_MAX;
    end
    else if (ce && wr_en)
      unique case (paddr)
        OFS_CTRL: {accum_en_r, mode_r} <= pwdata[CTRL_ACCUM:CTRL_MODE_LSB];
        OFS_AN_P1:
        begin
          p1_cur_r <= (pwdata[15:0] > ANA_CUR_MAX) ? ANA_CUR_MAX : pwdata[15:0];
          p1_flow_r <= pwdata[31:16];
        end
        OFS_AN_P2:
        begin
          p2_cur_r <= (pwdata[15:0] > ANA_CUR_MAX) ? ANA_CUR_MAX : pwdata[15:0];
          p2_flow_r <= pwdata[31:16];
        end
        OFS_PUL_CNT: pul_cnt_r <= pwdata[13:0];
        OFS_PUL_VOL: pul_vol_r <= pwdata[19:0];
        OFS_QUAL: qual_r <= pwdata[5:0];
        OFS_BAT_VOL: bat_vol_r <= pwdata[19:0];
        OFS_BAT_TIME: bat_time_r <= pwdata[16:0];
        OFS_CYC_DELAY: cyc_delay_r <= pwdata[10:0];
        OFS_CYC_DUR: {cyc_flow_r, cyc_dur_r} <= {pwdata[31:16], pwdata[10:0]};
        OFS_CYC_PERIOD: cyc_period_r <= pwdata[10:0];
        OFS_FLOW_MAX: flow_max_r <= pwdata[15:0];
        default: ;
      endcase

  // ****************************************************************
  // Millisecond tick and input synchronisers
  // ****************************************************************
  assign tick = ce && (tick_cnt_r == 17'(TICK_CYC - 1));

  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      tick_cnt_r <= 17'h0_0000;
    else if (ce)
      tick_cnt_r <= tick ? 17'h0_0000 : tick_cnt_r + 17'h0_0001;

  // Pins are asynchronous; the second stages and the remote edge delay rem_d_r feed logic
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      {pace_meta_r, pace_sync_r, rem_meta_r, rem_sync_r, rem_d_r} <= 5'h00;
    else if (ce)
    begin
      pace_meta_r <= fast_digital_input;
      pace_sync_r <= pace_meta_r;
      rem_meta_r <= remote_toggle;
      rem_sync_r <= rem_meta_r;
      rem_d_r <= rem_sync_r;
    end

  // Width qualification: pulse must stay high for qual_ms ticks
  assign qual_ms = (qual_r < QUAL_MIN_MS) ? QUAL_MIN_MS :
    (qual_r > QUAL_MAX_MS) ? QUAL_MAX_MS : qual_r;
  assign trig = tick && pace_sync_r && (qual_cnt_r == qual_ms - 6'h01);

  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      qual_cnt_r <= 6'h00;
    else if (ce && !pace_sync_r)
      qual_cnt_r <= 6'h00;
    else if (tick && qual_cnt_r != 6'h3F)
      qual_cnt_r <= qual_cnt_r + 6'h01;

  // Run state; a local write or a remote edge flips it, both in one cycle cancel
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      run_r <= 1'b0;
    else if (ce && toggle)
      run_r <= !run_r;

  // ****************************************************************
  // Analog mode
  // ****************************************************************
  assign ana_flow = interp(ana_current, p1_cur_r, p1_flow_r, p2_cur_r, p2_flow_r);

  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      {los_r, ovr_r} <= 2'h0;
    else if (ce)
    begin
      los_r <= (mode_r == MODE_ANALOG) && (ana_current <= ANA_LOS);
      ovr_r <= (mode_r == MODE_ANALOG) && (ana_current > ANA_OVR);
    end

  // ****************************************************************
  // Pulse mode: rate from the interval between qualified pulses
  // ****************************************************************
  assign nosync = (mode_r == MODE_PULSE) && (seen_r < 2'h2);
  assign maxexc = (mode_r == MODE_PULSE) && !nosync
    && (rate_r > {1'b0, flow_max_r});

  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      period_r <= 22'h00_0000;
      seen_r <= 2'h0;
      rate_r <= 17'h0_0000;
    end
    else if (ce && mode_r != MODE_PULSE)
      seen_r <= 2'h0;
    else if (trig)
    begin
      period_r <= 22'h00_0001;
      seen_r <= (seen_r == 2'h2) ? seen_r : seen_r + 2'h1;
      // Flow per hour = volume * ms per hour / (count * interval)
      if (seen_r != 2'h0)
        rate_r <= pulse_rate(pul_vol_r, pul_cnt_r, period_r);
    end
    else if (tick && period_r != 22'h3F_FFFF)
      period_r <= period_r + 22'h00_0001;

  // ****************************************************************
  // Batch mode
  // ****************************************************************
  // A zero dosing time is treated as one second to keep the divide safe
  assign bat_div = (bat_time_r == 17'h0_0000) ? 17'h0_0001 : bat_time_r;
  assign bat_flow = (32'(bat_vol_r) * S_PER_HOUR) / 32'(bat_div);
  assign bat_inv = (mode_r == MODE_BATCH) && (bat_flow > 32'(flow_max_r));
  assign cyc_inv = (mode_r == MODE_CYCLE) && (cyc_flow_r > flow_max_r);

  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      dosing_r <= 1'b0;
      rem_s_r <= 17'h0_0000;
      acc_r <= 16'h0000;
      bsub_r <= 16'h0000;
    end
    else if (ce && (!run_r || mode_r != MODE_BATCH))
    begin
      dosing_r <= 1'b0;
      acc_r <= 16'h0000;
      rem_s_r <= 17'h0_0000;
    end
    else if (trig && dosing_r && accum_en_r)
      acc_r <= (acc_r == 16'hFFFF) ? acc_r : acc_r + 16'h0001;
    else if (trig)
    begin
      dosing_r <= 1'b1;
      rem_s_r <= bat_div;
      bsub_r <= 16'h0000;
    end
    else if (tick && dosing_r)
    begin
      bsub_r <= (bsub_r == MS_PER_S - 16'h0001) ? 16'h0000 : bsub_r + 16'h0001;
      if (bsub_r == MS_PER_S - 16'h0001)
      begin
        if (rem_s_r != 17'h0_0001)
          rem_s_r <= rem_s_r - 17'h0_0001;
        else if (acc_r != 16'h0000)
        begin
          acc_r <= acc_r - 16'h0001;
          rem_s_r <= bat_div;
        end
        else
        begin
          dosing_r <= 1'b0;
          rem_s_r <= 17'h0_0000;
        end
      end
    end

  // Remaining volume and percentage follow the remaining seconds
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      rem_vol_r <= 20'h0_0000;
      pct_r <= 7'h00;
    end
    else if (ce)
    begin
      rem_vol_r <= 20'((37'(bat_vol_r) * 37'(rem_s_r)) / 37'(bat_div));
      pct_r <= 7'((32'(rem_s_r) * PCT_FULL) / 32'(bat_div));
    end

  // ****************************************************************
  // Cycle timer, minute resolution
  // ****************************************************************
  // Stopping drops to idle, so a restart always reruns the delay
  assign off_min = (cyc_period_r > cyc_dur_r + 11'h001) ? cyc_period_r - cyc_dur_r : 11'h001;

  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      ct_r <= CT_IDLE;
      ct_rem_r <= 11'h000;
      csub_r <= 16'h0000;
    end
    else if (ce && (!run_r || mode_r != MODE_CYCLE))
    begin
      ct_r <= CT_IDLE;
      ct_rem_r <= 11'h000;
    end
    else if (ce && ct_r == CT_IDLE)
    begin
      ct_r <= CT_DELAY;
      ct_rem_r <= (cyc_delay_r == 11'h000) ? 11'h001 : cyc_delay_r;
      csub_r <= 16'h0000;
    end
    else if (tick)
    begin
      csub_r <= (csub_r == MS_PER_MIN - 16'h0001) ? 16'h0000 : csub_r + 16'h0001;
      if (csub_r == MS_PER_MIN - 16'h0001)
      begin
        if (ct_rem_r != 11'h001)
          ct_rem_r <= ct_rem_r - 11'h001;
        else
          unique case (ct_r)
            CT_DELAY, CT_OFF:
            begin
              ct_r <= CT_ON;
              ct_rem_r <= (cyc_dur_r >= cyc_period_r) ? cyc_period_r - 11'h001 :
                cyc_dur_r;
            end
            CT_ON:
            begin
              ct_r <= CT_OFF;
              ct_rem_r <= off_min;
            end
            default: ct_r <= CT_IDLE;
          endcase
      end
    end

  // ****************************************************************
  // Commanded flow
  // ****************************************************************
  assign flow_cmd = flow_r;
  assign pump_run = run_r;

  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      flow_r <= 16'h0000;
    else if (ce)
    begin
      if (!run_r)
        flow_r <= 16'h0000;
      else
        unique case (mode_r)
          MODE_ANALOG: flow_r <= (ana_current <= ANA_LOS) ? 16'h0000 : ana_flow;
          MODE_PULSE: flow_r <= nosync ? 16'h0000 : maxexc ? flow_max_r :
            sat16(42'(rate_r));
          MODE_BATCH: flow_r <= !dosing_r ? 16'h0000 : (bat_flow > 32'(flow_max_r)) ?
            flow_max_r : sat16(42'(bat_flow));
          MODE_CYCLE: flow_r <= (ct_r == CT_ON) ? cyc_flow_r : 16'h0000;
        endcase
    end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  chk_ovr_flag_set: assert property (
    ce && mode_r == MODE_ANALOG && ana_current > ANA_OVR |=> ovr_r)
    else $error("over-range flag missed");
  chk_los_zero_flow: assert property (
    los_r |-> flow_r == 16'h0000 && $past(ana_current) <= ANA_LOS)
    else $error("flow not zero under loss of signal");
  chk_stop_zero_flow: assert property (
    ce && !run_r |=> flow_r == 16'h0000)
    else $error("flow while stopped");
  chk_run_toggle_flip: assert property (
    ce && toggle |=> run_r != $past(run_r))
    else $error("run state did not flip");
  chk_pulse_max_clamp: assert property (
    ce && run_r && maxexc |=> flow_r == $past(flow_max_r))
    else $error("pulse flow not clamped");
  chk_batch_start_load: assert property (
    trig && run_r && mode_r == MODE_BATCH && !(dosing_r && accum_en_r)
    |=> dosing_r && rem_s_r == $past(bat_div))
    else $error("batch did not start");
  chk_accum_count_up: assert property (
    trig && run_r && mode_r == MODE_BATCH && dosing_r && accum_en_r && acc_r != 16'hFFFF
    |=> acc_r == $past(acc_r) + 16'h0001 && dosing_r)
    else $error("extra trigger not counted");
  chk_cycle_delay_first: assert property (
    ce && run_r && mode_r == MODE_CYCLE && ct_r == CT_IDLE |=> ct_r == CT_DELAY)
    else $error("cycle timer skipped delay");
  chk_cycle_stop_cancel: assert property (
    ce && !run_r && ct_r != CT_IDLE |=> ct_r == CT_IDLE ##1 flow_r == 16'h0000)
    else $error("stop did not cancel cycle timer");
endmodule

//--- hdl/dmc_pkg.sv
// Constants, register map and types of the dosing mode controller
package dmc_pkg;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [15:0] MS_PER_S = 16'h03E8;
  localparam logic [15:0] MS_PER_MIN = 16'hEA60;
  localparam logic [41:0] MS_PER_HOUR = 42'h36_EE80;
  localparam logic [31:0] S_PER_HOUR = 32'h0000_0E10;
  localparam logic [5:0] QUAL_MIN_MS = 6'h04;
  localparam logic [5:0] QUAL_MAX_MS = 6'h3C;
  localparam logic [31:0] PCT_FULL = 32'h0000_0064;
  // ****************************************************************
  // Analog thresholds, current LSB is 10 uA
  // ****************************************************************
  localparam logic [15:0] ANA_CUR_MAX = 16'h07D0;
  localparam logic [15:0] ANA_OVR = 16'h0898;
  localparam logic [15:0] ANA_LOS = 16'h0032;
  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_AN_P1 = 8'h04;
  localparam logic [7:0] OFS_AN_P2 = 8'h08;
  localparam logic [7:0] OFS_PUL_CNT = 8'h0C;
  localparam logic [7:0] OFS_PUL_VOL = 8'h10;
  localparam logic [7:0] OFS_QUAL = 8'h14;
  localparam logic [7:0] OFS_BAT_VOL = 8'h18;
  localparam logic [7:0] OFS_BAT_TIME = 8'h1C;
  localparam logic [7:0] OFS_CYC_DELAY = 8'h20;
  localparam logic [7:0] OFS_CYC_DUR = 8'h24;
  localparam logic [7:0] OFS_CYC_PERIOD = 8'h28;
  localparam logic [7:0] OFS_FLOW_MAX = 8'h2C;
  localparam logic [7:0] OFS_STATUS = 8'h30;
  localparam logic [7:0] OFS_FLOW = 8'h34;
  localparam logic [7:0] OFS_REM_VOL = 8'h38;
  localparam logic [7:0] OFS_REM_TIME = 8'h3C;
  localparam logic [7:0] OFS_REM_PCT = 8'h40;
  // Control fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_ACCUM = 2;
  localparam int CTRL_TOGGLE = 3;
  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [13:0] RST_PUL_CNT = 14'h0001;
  localparam logic [19:0] RST_VOL = 20'h0_0001;
  localparam logic [5:0] RST_QUAL = 6'h04;
  localparam logic [16:0] RST_BAT_TIME = 17'h0_0001;
  localparam logic [10:0] RST_CYC_MIN = 11'h001;
  localparam logic [10:0] RST_CYC_PERIOD = 11'h002;
  localparam logic [15:0] RST_FLOW_MAX = 16'hFFFF;
  // ****************************************************************
  // Modes and cycle timer phases
  // ****************************************************************
  localparam logic [1:0] MODE_ANALOG = 2'h0;
  localparam logic [1:0] MODE_PULSE = 2'h1;
  localparam logic [1:0] MODE_BATCH = 2'h2;
  localparam logic [1:0] MODE_CYCLE = 2'h3;
  typedef enum logic [1:0] {CT_IDLE, CT_DELAY, CT_ON, CT_OFF} dmc_ct_state_t;
endpackage

//--- tb/dmc_src_model.sv
// Model of the far side: current loop and pacing pulse source
`timescale 1ns/1ps
module dmc_src_model (
  input wire logic ref_clk,
  output logic [15:0] ana_current,
  output logic pulse_out
);
  // ****************************************************************
  // Loop current and pulse pin
  // ****************************************************************
  // Pin idles low between pulses; loop starts at zero current
  initial
  begin
    ana_current = 16'h0000;
    pulse_out = 1'b0;
  end
  // Current steps just after an edge, like a sampled converter
  task set_current(input logic [15:0] v);
    ana_current <= v;
    // Let the registered flags follow before anyone reads them
    repeat (2) @(posedge ref_clk);
  endtask
  // Pulses stay wider than the qualification time, on the fast input
  task send_pulse(input int hi, input int lo);
    pulse_out <= 1'b1;
    repeat (hi) @(posedge ref_clk);
    pulse_out <= 1'b0;
    repeat (lo) @(posedge ref_clk);
  endtask
endmodule

//--- tb/testbench.sv
// Self-checking bench of the dosing mode controller
`timescale 1ns/1ps
module testbench;
  import dmc_pkg::*;
  // Short tick keeps second-long batches within the run budget
  localparam int TK = 10;
  logic ref_clk, rst_n, ce, psel, penable, pwrite, remote_toggle;
  logic pready, pslverr, err, pump_run, fast_digital_input;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] ana_current, flow_cmd;
  int n_mismatch, tests_run, cyc;
  dmc_top #(.TICK_CYC(TK)) uut (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ana_current(ana_current),
    .fast_digital_input(fast_digital_input), .remote_toggle(remote_toggle),
    .flow_cmd(flow_cmd), .pump_run(pump_run));
  dmc_src_model src (.ref_clk(ref_clk), .ana_current(ana_current),
    .pulse_out(fast_digital_input));
  // ****************************************************************
  // Clock, timeout and shared tasks
  // ****************************************************************
  // Free-running 100 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // A hang counts as a mismatch and closes the run
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      n_mismatch++;
      end_sim();
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task end_sim();
    $display("Counts: %0d checks, %0d mismatches", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // One APB transfer; request held until pready is sampled high
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
      n_mismatch++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task st(input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    check(rd & m, e);
  endtask
  task wait_ms(input int n);
    repeat (n * TK) @(posedge ref_clk);
  endtask
  // Pulses start on a fixed tick phase so intervals are whole ms
  task pulse();
    while (cyc % TK != 0)
      @(posedge ref_clk);
    src.send_pulse(6 * TK, 3 * TK);
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task t_reset();
    check({31'h0, pump_run}, 32'h0000_0000);
    apb(1'b0, OFS_PUL_CNT, 32'h0000_0000);
    check(rd, 32'h0000_0001);
    apb(1'b0, OFS_QUAL, 32'h0000_0000);
    check(rd, 32'h0000_0004);
    st(32'hFFFF_FFFF, 32'h0000_0002);
    apb(1'b0, 8'h44, 32'h0000_0000);
    check({rd[30:0], err}, 32'h0000_0001);
    $display("reset test done");
  endtask
  task t_analog();
    apb(1'b1, OFS_AN_P1, 32'h03E8_0190);
    apb(1'b1, OFS_AN_P2, 32'h1388_0640);
    apb(1'b1, OFS_CTRL, 32'h0000_0008);
    src.set_current(16'h03E8);
    wait_ms(1);
    check({16'h0, flow_cmd}, 32'h0000_0BB8);
    check({31'h0, pump_run}, 32'h0000_0001);
    src.set_current(16'h07D0);
    wait_ms(1);
    check({16'h0, flow_cmd}, 32'h0000_1388);
    src.set_current(16'h0899);
    st(32'h0000_001F, 32'h0000_0005);
    src.set_current(16'h0032);
    st(32'h0000_001F, 32'h0000_0003);
    check({16'h0, flow_cmd}, 32'h0000_0000);
    src.set_current(16'h0033);
    st(32'h0000_001F, 32'h0000_0001);
    check({16'h0, flow_cmd}, 32'h0000_03E8);
    remote_toggle <= 1'b1;
    wait_ms(1);
    remote_toggle <= 1'b0;
    wait_ms(1);
    check({31'h0, pump_run}, 32'h0000_0000);
    $display("analog test done");
  endtask
  task t_pulse();
    apb(1'b1, OFS_FLOW_MAX, 32'h0000_1000);
    apb(1'b1, OFS_CTRL, 32'h0000_0009);
    pulse();
    st(32'h0000_001F, 32'h0000_0009);
    pulse();
    st(32'h0000_001F, 32'h0000_0011);
    check({16'h0, flow_cmd}, 32'h0000_1000);
    apb(1'b1, OFS_PUL_CNT, 32'h0000_0064);
    pulse();
    st(32'h0000_001F, 32'h0000_0001);
    check({16'h0, flow_cmd}, 32'h0000_0E10);
    $display("pulse test done");
  endtask
  task t_batch();
    apb(1'b1, OFS_CTRL, 32'h0000_0002);
    pulse();
    st(32'h0000_0021, 32'h0000_0021);
    check({16'h0, flow_cmd}, 32'h0000_0E10);
    apb(1'b0, OFS_REM_PCT, 32'h0000_0000);
    check(rd, 32'h0000_0064);
    wait_ms(500);
    pulse();
    wait_ms(600);
    st(32'h0000_0020, 32'h0000_0020);
    wait_ms(500);
    st(32'h0000_0020, 32'h0000_0000);
    apb(1'b1, OFS_CTRL, 32'h0000_0006);
    pulse();
    wait_ms(500);
    pulse();
    wait_ms(1100);
    st(32'h0000_0020, 32'h0000_0020);
    wait_ms(500);
    st(32'h0000_0020, 32'h0000_0000);
    apb(1'b1, OFS_FLOW_MAX, 32'h0000_0E0F);
    st(32'h0000_0040, 32'h0000_0040);
    $display("batch test done");
  endtask
  task t_cycle();
    apb(1'b1, OFS_FLOW_MAX, 32'h0000_1000);
    apb(1'b1, OFS_CTRL, 32'h0000_0003);
    st(32'h07FF_0381, 32'h0001_0101);
    check({16'h0, flow_cmd}, 32'h0000_0000);
    apb(1'b1, OFS_CYC_DUR, 32'h2000_0001);
    st(32'h0000_0080, 32'h0000_0080);
    // Clock enable low: the transfer must wait, then finish once enabled
    ce <= 1'b0;
    fork
      apb(1'b0, OFS_CYC_DELAY, 32'h0000_0000);
      begin
        repeat (5) @(posedge ref_clk);
        check({31'h0, pready}, 32'h0000_0000);
        ce <= 1'b1;
      end
    join
    check(rd, 32'h0000_0001);
    apb(1'b1, OFS_CTRL, 32'h0000_000B);
    st(32'h0000_0301, 32'h0000_0000);
    check({16'h0, flow_cmd}, 32'h0000_0000);
    apb(1'b1, OFS_CTRL, 32'h0000_000B);
    st(32'h07FF_0301, 32'h0001_0101);
    $display("cycle test done");
  endtask
  // Main sequence: reset held for 10 cycles, then each scenario
  initial
  begin
    rst_n = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    remote_toggle = 1'b0;
    n_mismatch = 0;
    tests_run = 0;
    cyc = 0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    t_analog();
    t_pulse();
    t_batch();
    t_cycle();
    end_sim();
  end
endmodule
